// *** rtl/aux_intc.sv ***
// Interrupt controller: flags, enables, priorities, vector selection, wake-up.
// Assumes the core samples the vector while int_req_o is high, pulses
// vec_ack_i when it vectors and reti_i when a service routine returns.
//
// Operation
// - Three tiers: auxiliary group on top, others high or low by priority bit.
// - Seven auxiliary sources share vector 0x33, number 6, above all others.
// - Aux pending and enable bits 1..7 in listed order; bit 0 zero; reset zero.
// - Enabled aux request sets group flag; group reaches core only with group enable.
// - Ext0, timer0, ext1, timer1, serial vector to 0x03..0x23, numbers 0..4.
// - Ext2..5 vector 0x43..0x5B as 8..11; watchdog 0x63 as 12.
// - Same tier: fixed natural order, aux first, watchdog last.
// - Edge-triggered classic pin flag clears when its routine is vectored; ext2..5 flags clear only by software write.
// - Level-triggered external pin flag follows the pin continuously.
// - Trigger-type bit per classic pin: 0 level, 1 edge.
// - Timer overflow flags clear by hardware when their vector is taken.
// - Global enable gates every non-auxiliary source.
// - Serial interrupt requested by receive or transmit flag.
// - Pin flag register: ext5..2 at 7..4, bit 3 one; reset 0x08.
// - Extended control: group enable 5, group flag 4, watchdog flag 3; reset 0x40.
// - Read-only aux status shows raw source conditions at bits 7..1.
// - Wake-up enable: watchdog bit 2, ext1 bit 1, ext0 bit 0; reset zero.
// - Idle ends only through aux-enabled or wake-enabled interrupts.
// - Reading the lowest converter result byte clears converter pending bit.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

module aux_intc
  import aux_intc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Register port
  input  wire logic [7:0]   addr_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [7:0]   rdata_o,
  // Event sources
  input  wire logic [5:0]   ext_pin_n_i,
  input  wire logic [1:0]   timer_ovf_i,
  input  wire logic [1:0]   serial_flags_i,
  input  wire logic         watchdog_evt_i,
  input  wire logic [7:1]   aux_cond_i,
  // Core side
  input  wire logic         vec_ack_i,
  input  wire logic         reti_i,
  output logic              int_req_o,
  output logic      [7:0]   int_vector_o,
  output logic      [3:0]   int_num_o,
  output logic              wake_o,
  output logic      [1:0]   timer_run_o
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic tier_type src_tier(input int i, input logic hi);
    if (i == SRC_AUX) begin
      return TIER_AUX;
    end else if (hi) begin
      return TIER_HIGH;
    end else begin
      return TIER_LOW;
    end
  endfunction

  // Highest allowed tier first, then lowest index within it
  function automatic grant_type pick_winner(input logic [NUM_SRC-1:0] req,
                                            input logic [NUM_SRC-1:0] hi,
                                            input logic [2:0]         allow);
    grant_type g;
    g = '0;
    for (int t = 2; t >= 0; t--) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (!g.valid && allow[t] && req[i] && src_tier(i, hi[i]) == tier_type'(t[1:0])) begin
          g.valid = 1'b1;
          g.tier  = tier_type'(t[1:0]);
          g.idx   = i[3:0];
        end
      end
    end
    return g;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [1:0]   ext_type_q;
  logic [1:0]   ext_pend_q;
  logic [5:0]   pin_prev_q;
  logic [1:0]   tf_q;
  logic [1:0]   tr_q;
  logic [3:0]   extended_pin_flags_q;
  logic [7:1]   aip_q;
  logic [7:1]   aie_q;
  logic [7:1]   ast_q;
  logic         eai_q;
  logic         watchdog_int_flag_q;
  logic [7:0]   ie_q;
  logic [4:0]   ip_q;
  logic [4:0]   eie_q;
  logic [4:0]   eip_q;
  logic [2:0]   ewu_q;
  logic [2:0]   active_q;
  grant_type    grant_q;
  logic [5:0]   fall;
  logic         ai_flag;
  logic [3:0]   aux_priority_index;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] hi;
  logic [2:0]   allow;
  grant_type    win;
  logic         wr_tc;
  logic         taken_ex0;
  logic         taken_ex1;

  assign fall      = pin_prev_q & ~ext_pin_n_i;
  assign wr_tc     = wr_i && addr_i == TIMER_CONTROL_ADDR;
  assign taken_ex0 = vec_ack_i && grant_q.idx == 4'(SRC_EX0);
  assign taken_ex1 = vec_ack_i && grant_q.idx == 4'(SRC_EX1);
  assign ai_flag   = |(aip_q & aie_q);

  always_comb begin
    aux_priority_index = 4'h0;
    // Ascending scan so the highest-numbered pending source is reported last
    for (int i = 1; i < 8; i++) begin
      if (aip_q[i] && aie_q[i]) begin
        aux_priority_index = i[3:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Classic pins and timer flags
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_prev_q <= '1;
    end else begin
      pin_prev_q <= ext_pin_n_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_type_q <= '0;
      ext_pend_q <= '0;
      tr_q       <= '0;
    end else begin
      if (wr_tc) begin
        ext_type_q <= {wdata_i[2], wdata_i[0]};
        tr_q       <= {wdata_i[TC_TR1], wdata_i[TC_TR0]};
      end
      for (int k = 0; k < 2; k++) begin
        if (!ext_type_q[k]) begin
          ext_pend_q[k] <= ~ext_pin_n_i[k];
        end else if (fall[k]) begin
          ext_pend_q[k] <= 1'b1;
        end else if (wr_tc) begin
          ext_pend_q[k] <= wdata_i[2*k+1];
        end else if (k == 0 ? taken_ex0 : taken_ex1) begin
          ext_pend_q[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tf_q <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (timer_ovf_i[k]) begin
          tf_q[k] <= 1'b1;
        end else if (wr_tc) begin
          tf_q[k] <= wdata_i[k == 0 ? TC_TF0 : TC_TF1];
        end else if (vec_ack_i && grant_q.idx == (k == 0 ? 4'(SRC_T0) : 4'(SRC_T1))) begin
          tf_q[k] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Extended pins, watchdog and auxiliary flags
  // ------------------------------------------------------------------
  // Set beats a software clear in the same cycle, so no event is lost
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      extended_pin_flags_q <= '0;
      watchdog_int_flag_q <= 1'b0;
      aip_q  <= '0;
      ast_q  <= '0;
    end else begin
      ast_q <= aux_cond_i;
      if (wr_i && addr_i == EXTENDED_PIN_FLAGS_ADDR) begin
        extended_pin_flags_q <= wdata_i[7:4] | fall[5:2];
      end else begin
        extended_pin_flags_q <= extended_pin_flags_q | fall[5:2];
      end
      if (watchdog_evt_i) begin
        watchdog_int_flag_q <= 1'b1;
      end else if (wr_i && addr_i == EXTENDED_CONTROL_ADDR) begin
        watchdog_int_flag_q <= wdata_i[EC_WDT_FLAG];
      end
      for (int i = 1; i < 8; i++) begin
        if (aux_cond_i[i] && !ast_q[i]) begin
          aip_q[i] <= 1'b1;
        end else if (wr_i && addr_i == AUX_PENDING_ADDR) begin
          aip_q[i] <= aip_q[i] & wdata_i[i];
        end else if (i == AUX_CONV_BIT && rd_i && addr_i == CONV_RESULT_LOW_ADDR) begin
          aip_q[i] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Enables, priorities and wake-up
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aie_q <= '0;
      eai_q <= 1'b0;
      ie_q  <= '0;
      ip_q  <= '0;
      eie_q <= '0;
      eip_q <= '0;
      ewu_q <= '0;
    end else if (wr_i) begin
      case (addr_i)
        AUX_ENABLE_ADDR:         aie_q <= wdata_i[7:1];
        EXTENDED_CONTROL_ADDR:   eai_q <= wdata_i[EC_GROUP_ENABLE];
        INTERRUPT_ENABLE_ADDR:   ie_q  <= {wdata_i[7], 2'b00, wdata_i[4:0]};
        INTERRUPT_PRIORITY_ADDR: ip_q  <= wdata_i[4:0];
        EXTENDED_ENABLE_ADDR:    eie_q <= wdata_i[4:0];
        EXTENDED_PRIORITY_ADDR:  eip_q <= wdata_i[4:0];
        WAKEUP_ENABLE_ADDR:      ewu_q <= wdata_i[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= ai_flag | (watchdog_int_flag_q & ewu_q[2]) | (ext_pend_q[1] & ewu_q[1])
                | (ext_pend_q[0] & ewu_q[0]);
    end
  end

  // ------------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        TIMER_CONTROL_ADDR:      rdata_o <= {tf_q[1], tr_q[1], tf_q[0], tr_q[0], ext_pend_q[1],
                                             ext_type_q[1], ext_pend_q[0], ext_type_q[0]};
        EXTENDED_PIN_FLAGS_ADDR: rdata_o <= {extended_pin_flags_q, 4'h0} | EXTENDED_PIN_FLAGS_RST;
        AUX_PENDING_ADDR:        rdata_o <= {aip_q, 1'b0};
        AUX_PRIORITY_INDEX_ADDR: rdata_o <= {4'h0, aux_priority_index};
        AUX_ENABLE_ADDR:         rdata_o <= {aie_q, 1'b0};
        AUX_STATUS_ADDR:         rdata_o <= {ast_q, 1'b0};
        INTERRUPT_ENABLE_ADDR:   rdata_o <= ie_q;
        INTERRUPT_PRIORITY_ADDR: rdata_o <= {3'b000, ip_q} | INTERRUPT_PRIORITY_RST;
        WAKEUP_ENABLE_ADDR:      rdata_o <= {5'h00, ewu_q};
        EXTENDED_CONTROL_ADDR:   rdata_o <= {2'b00, eai_q, ai_flag, watchdog_int_flag_q, 3'b000}
                                            | EXTENDED_CONTROL_RST;
        EXTENDED_ENABLE_ADDR:    rdata_o <= {3'b000, eie_q} | EXTENDED_ENABLE_RST;
        EXTENDED_PRIORITY_ADDR:  rdata_o <= {3'b000, eip_q} | EXTENDED_PRIORITY_RST;
        default:                 rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // ------------------------------------------------------------------
  // Arbitration and vectoring
  // ------------------------------------------------------------------
  always_comb begin
    req[SRC_AUX] = eai_q & ai_flag;
    req[SRC_EX0] = ie_q[IE_GLOBAL] & ie_q[0] & ext_pend_q[0];
    req[SRC_T0]  = ie_q[IE_GLOBAL] & ie_q[1] & tf_q[0];
    req[SRC_EX1] = ie_q[IE_GLOBAL] & ie_q[2] & ext_pend_q[1];
    req[SRC_T1]  = ie_q[IE_GLOBAL] & ie_q[3] & tf_q[1];
    req[SRC_SER] = ie_q[IE_GLOBAL] & ie_q[4] & (|serial_flags_i);
    for (int j = 0; j < 4; j++) begin
      req[SRC_EX2+j] = ie_q[IE_GLOBAL] & eie_q[j] & extended_pin_flags_q[j];
    end
    req[SRC_WDT] = ie_q[IE_GLOBAL] & eie_q[4] & watchdog_int_flag_q;
    hi = {eip_q, ip_q, 1'b1};
    // A request must outrank every routine in service
    allow = {~active_q[2], ~|active_q[2:1], ~|active_q};
  end

  assign win = pick_winner(req, hi, allow);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      grant_q      <= '0;
      int_req_o    <= 1'b0;
      int_vector_o <= '0;
      int_num_o    <= '0;
    end else begin
      // Dropped in the ack cycle so a stale grant is never offered twice
      int_req_o    <= win.valid & ~vec_ack_i;
      grant_q      <= win;
      int_vector_o <= VEC_ADDR[win.idx];
      int_num_o    <= VEC_NUM[win.idx];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_q <= '0;
    end else if (vec_ack_i && int_req_o) begin
      active_q[grant_q.tier] <= 1'b1;
    end else if (reti_i) begin
      if (active_q[2]) begin
        active_q[2] <= 1'b0;
      end else if (active_q[1]) begin
        active_q[1] <= 1'b0;
      end else begin
        active_q[0] <= 1'b0;
      end
    end
  end

  assign timer_run_o = tr_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_t0_taken;
    vec_ack_i && grant_q.idx == 4'(SRC_T0) && !timer_ovf_i[0] && !wr_tc;
  endsequence

  sequence s_ex0_edge_taken;
    taken_ex0 && ext_type_q[0] && !fall[0] && !wr_tc;
  endsequence

  a_aux_vector_addr: assert property (
    int_req_o && grant_q.idx == 4'(SRC_AUX) |-> int_vector_o == 8'h33 && int_num_o == 4'h6)
    else $error("aux group vector wrong");
  a_wdt_vector_addr: assert property (
    int_req_o && grant_q.idx == 4'(SRC_WDT) |-> int_vector_o == 8'h63 && int_num_o == 4'hC)
    else $error("watchdog vector wrong");
  a_global_gate_off: assert property (
    int_req_o && grant_q.idx != 4'(SRC_AUX) |-> $past(ie_q[IE_GLOBAL]))
    else $error("request passed with global enable clear");
  a_timer_auto_clear: assert property (s_t0_taken |=> !tf_q[0])
    else $error("timer 0 flag not cleared on vectoring");
  a_edge_auto_clear: assert property (s_ex0_edge_taken |=> !ext_pend_q[0])
    else $error("edge flag not cleared on vectoring");
  a_level_flag_track: assert property (
    !ext_type_q[0] && !wr_tc |=> ext_pend_q[0] == !$past(ext_pin_n_i[0]))
    else $error("level flag does not follow pin");
  a_prio_read_const: assert property (
    rd_i && addr_i == INTERRUPT_PRIORITY_ADDR |=> rdata_o[7:5] == 3'b100)
    else $error("priority constant bits wrong");
  a_group_flag_read: assert property (
    rd_i && addr_i == EXTENDED_CONTROL_ADDR |=> rdata_o[EC_GROUP_FLAG] == $past(ai_flag))
    else $error("group flag read wrong");
  a_conv_read_clear: assert property (
    rd_i && addr_i == CONV_RESULT_LOW_ADDR && !(aux_cond_i[5] && !ast_q[5]) |=> !aip_q[5])
    else $error("converter pending not cleared by read");
  a_no_preempt_same: assert property (
    int_req_o |-> !active_q[grant_q.tier] || $past(vec_ack_i))
    else $error("equal tier preempted running routine");

endmodule

// *** rtl/aux_intc_pkg.sv ***
// Constants, register map and carrier types of the interrupt controller.
// Assumes an 8-bit register space reached over a plain strobe port.
package aux_intc_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] TIMER_CONTROL_ADDR      = 8'h88;
  localparam logic [7:0] EXTENDED_PIN_FLAGS_ADDR = 8'h91;
  localparam logic [7:0] AUX_PENDING_ADDR        = 8'hA4;
  localparam logic [7:0] AUX_PRIORITY_INDEX_ADDR = 8'hA5;
  localparam logic [7:0] AUX_ENABLE_ADDR         = 8'hA6;
  localparam logic [7:0] AUX_STATUS_ADDR         = 8'hA7;
  localparam logic [7:0] INTERRUPT_ENABLE_ADDR   = 8'hA8;
  localparam logic [7:0] INTERRUPT_PRIORITY_ADDR = 8'hB8;
  localparam logic [7:0] WAKEUP_ENABLE_ADDR      = 8'hC6;
  localparam logic [7:0] EXTENDED_CONTROL_ADDR   = 8'hD8;
  localparam logic [7:0] CONV_RESULT_LOW_ADDR    = 8'hD9;
  localparam logic [7:0] EXTENDED_ENABLE_ADDR    = 8'hE8;
  localparam logic [7:0] EXTENDED_PRIORITY_ADDR  = 8'hF8;

  // ------------------------------------------------------------------
  // Reset values and constant bits
  // ------------------------------------------------------------------
  localparam logic [7:0] INTERRUPT_PRIORITY_RST = 8'h80;
  localparam logic [7:0] EXTENDED_ENABLE_RST    = 8'hE0;
  localparam logic [7:0] EXTENDED_PRIORITY_RST  = 8'hE0;
  localparam logic [7:0] EXTENDED_PIN_FLAGS_RST = 8'h08;
  localparam logic [7:0] EXTENDED_CONTROL_RST   = 8'h40;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;
  localparam int EC_GROUP_ENABLE = 5;
  localparam int EC_GROUP_FLAG   = 4;
  localparam int EC_WDT_FLAG     = 3;
  localparam int IE_GLOBAL       = 7;
  localparam int AUX_CONV_BIT    = 5;

  // ------------------------------------------------------------------
  // Sources, in natural order, with their vectors
  // ------------------------------------------------------------------
  localparam int NUM_SRC = 11;
  localparam int SRC_AUX = 0;
  localparam int SRC_EX0 = 1;
  localparam int SRC_T0  = 2;
  localparam int SRC_EX1 = 3;
  localparam int SRC_T1  = 4;
  localparam int SRC_SER = 5;
  localparam int SRC_EX2 = 6;
  localparam int SRC_WDT = 10;
  localparam logic [7:0] VEC_ADDR [NUM_SRC] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23,
                                               8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
  localparam logic [3:0] VEC_NUM [NUM_SRC]  = '{4'h6, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                                               4'h8, 4'h9, 4'hA, 4'hB, 4'hC};

  typedef enum logic [1:0] {
    TIER_LOW  = 2'b00,
    TIER_HIGH = 2'b01,
    TIER_AUX  = 2'b10
  } tier_type;

  typedef struct packed {
    logic       valid;
    tier_type   tier;
    logic [3:0] idx;
  } grant_type;

endpackage

// *** tb/core_model.sv ***
// Behavioural processor core: takes presented vectors and returns on command.
// Assumes the controller holds its request until the acknowledge is sampled.
`timescale 1ns/1ps

module core_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Bench controls
  input  wire logic       take_i,
  input  wire logic [1:0] delay_i,
  input  wire logic       ret_i,
  // Controller side
  input  wire logic       int_req_i,
  input  wire logic [7:0] vector_i,
  input  wire logic [3:0] num_i,
  output logic            vec_ack_o,
  output logic            reti_o,
  // Observation
  output logic [7:0]      vector_o,
  output logic [3:0]      num_o,
  output logic [7:0]      acks_o
);
  // ------------------------------------------------------------------
  // Vector fetch and return
  // ------------------------------------------------------------------
  logic [1:0] wait_q;
  logic [3:0] depth_q;

  // Vector is latched at the edge that samples the acknowledge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vec_ack_o <= 1'b0;
      wait_q    <= 2'h0;
      vector_o  <= 8'h00;
      num_o     <= 4'h0;
      acks_o    <= 8'h00;
    end else if (vec_ack_o) begin
      vec_ack_o <= 1'b0;
      vector_o  <= vector_i;
      num_o     <= num_i;
      acks_o    <= acks_o + 8'h01;
    end else if (take_i && int_req_i) begin
      if (wait_q == delay_i) begin
        vec_ack_o <= 1'b1;
        wait_q    <= 2'h0;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end else begin
      wait_q <= 2'h0;
    end
  end

  // A return is only issued while some routine is in service
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reti_o  <= 1'b0;
      depth_q <= 4'h0;
    end else begin
      reti_o  <= ret_i && (depth_q != 4'h0);
      depth_q <= depth_q + 4'(vec_ack_o) - 4'(reti_o);
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench: register map, vectors, gating, order and nesting.
// Assumes the core model acknowledges every request it is allowed to take.
`timescale 1ns/1ps

module testbench;
  // ------------------------------------------------------------------
  // Stimulus, instances and tables
  // ------------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [5:0]  pin_n = 6'h3f;
  logic [1:0]  tovf = 2'h0;
  logic [1:0]  ser = 2'h0;
  logic        wdt = 1'b0;
  logic [7:1]  aux = 7'h00;
  logic        take = 1'b1;
  logic [1:0]  dly = 2'h0;
  logic        ret_cmd = 1'b0;
  logic [7:0]  rdata_o, vec, vec_seen, acks;
  logic [3:0]  num, num_seen;
  logic        req, wake, ack, reti;
  logic [1:0]  trun;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [7:0]  vec_tbl [10] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
                                8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
  logic [3:0]  num_tbl [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  logic [15:0] rst_tbl [13] = '{16'h8800, 16'h9108, 16'ha400, 16'ha500, 16'ha600, 16'ha700,
                                16'ha800, 16'hb880, 16'hc600, 16'hd840, 16'he8e0, 16'hf8e0,
                                16'h9000};
  // Address, write data, read-back; pairs restore the reset state
  logic [23:0] wr_tbl [15] = '{24'ha8_ff9f, 24'ha8_0000, 24'hb8_ff9f, 24'hb8_0080,
                               24'he8_00e0, 24'hf8_1fff, 24'hf8_00e0, 24'h91_0008,
                               24'hd8_2060, 24'hd8_0040, 24'hc6_0707, 24'hc6_0000,
                               24'ha6_fffe, 24'ha6_0000, 24'h90_ff00};

  always #10 clk_i = ~clk_i;

  aux_intc dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_pin_n_i(pin_n),
    .timer_ovf_i(tovf), .serial_flags_i(ser), .watchdog_evt_i(wdt),
    .aux_cond_i(aux), .vec_ack_i(ack), .reti_i(reti), .int_req_o(req),
    .int_vector_o(vec), .int_num_o(num), .wake_o(wake), .timer_run_o(trun)
  );

  core_model core_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .take_i(take), .delay_i(dly), .ret_i(ret_cmd),
    .int_req_i(req), .vector_i(vec), .num_i(num), .vec_ack_o(ack), .reti_o(reti),
    .vector_o(vec_seen), .num_o(num_seen), .acks_o(acks)
  );

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit c);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    if (c) chk($sformatf("reg %h", a), rdata_o, e);
  endtask

  task automatic ret();
    @(posedge clk_i);
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
  endtask

  task automatic wait_ack(input logic [7:0] v, input logic [3:0] n);
    logic [7:0] a0;
    int         i;
    a0 = acks;
    i = 0;
    while (acks === a0 && i < 40) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    if (acks === a0) begin
      chk("ack wait", 8'h00, 8'h01);
      tally_and_finish();
    end else begin
      chk("vector", vec_seen, v);
      chk("number", {4'h0, num_seen}, {4'h0, n});
    end
  endtask

  // Source k in natural order: ext0, t0, ext1, t1, serial, ext2..5, watchdog
  task automatic fire(input int k);
    @(posedge clk_i);
    case (k)
      0, 2:    pin_n[k / 2] <= 1'b0;
      1, 3:    tovf[k / 2] <= 1'b1;
      4:       ser <= 2'h1;
      9:       wdt <= 1'b1;
      default: pin_n[k - 3] <= 1'b0;
    endcase
    @(posedge clk_i);
    tovf <= 2'h0;
    wdt <= 1'b0;
  endtask

  initial begin
    logic [7:0] ie;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rst_tbl[i]) rd(rst_tbl[i][15:8], rst_tbl[i][7:0], 1'b1);
    foreach (wr_tbl[i]) begin
      wr(wr_tbl[i][23:16], wr_tbl[i][15:8]);
      rd(wr_tbl[i][23:16], wr_tbl[i][7:0], 1'b1);
    end
    $display("test register map done");
    wr(8'h88, 8'h05);
    for (int k = 0; k < 10; k++) begin
      dly <= 2'(k % 3);
      ie = (k < 5) ? 8'(1 << k) : 8'h00;
      if (k < 5) wr(8'ha8, ie);
      else wr(8'he8, 8'(1 << (k - 5)));
      fire(k);
      tick(4);
      #1;
      chk("request", 8'(req), 8'h00);
      wr(8'ha8, ie | 8'h80);
      wait_ack(vec_tbl[k], num_tbl[k]);
      @(posedge clk_i);
      pin_n <= 6'h3f;
      ser <= 2'h0;
      if (k < 4) rd(8'h88, 8'h05, 1'b1);
      wr(8'h91, 8'h08);
      wr(8'hd8, 8'h00);
      wr(8'ha8, 8'h00);
      wr(8'he8, 8'h00);
      ret();
    end
    $display("test vectors done");
    wr(8'h88, 8'h50);
    pin_n[0] <= 1'b0;
    tick(4);
    rd(8'h88, 8'h52, 1'b1);
    chk("timer run", {6'h00, trun}, 8'h03);
    tick(1);
    pin_n[0] <= 1'b1;
    tick(4);
    rd(8'h88, 8'h50, 1'b1);
    wr(8'h88, 8'h05);
    fire(0);
    tick(4);
    #1;
    chk("wake", 8'(wake), 8'h00);
    wr(8'hc6, 8'h01);
    tick(2);
    #1;
    chk("wake", 8'(wake), 8'h01);
    tick(1);
    pin_n <= 6'h3f;
    wr(8'h88, 8'h05);
    wr(8'hc6, 8'h00);
    $display("test pins and wake done");
    wr(8'ha6, 8'h20);
    aux[5] <= 1'b1;
    tick(4);
    #1;
    chk("request", 8'(req), 8'h00);
    chk("wake", 8'(wake), 8'h01);
    rd(8'hd8, 8'h50, 1'b1);
    rd(8'ha4, 8'h20, 1'b1);
    rd(8'ha7, 8'h20, 1'b1);
    rd(8'ha5, 8'h05, 1'b1);
    wr(8'hd8, 8'h20);
    wait_ack(8'h33, 4'h6);
    rd(8'hd9, 8'h00, 1'b0);
    rd(8'ha4, 8'h00, 1'b1);
    tick(1);
    aux <= 7'h00;
    wr(8'hd8, 8'h00);
    wr(8'ha6, 8'h00);
    ret();
    $display("test aux group done");
    take <= 1'b0;
    wr(8'ha8, 8'h87);
    wr(8'hb8, 8'h04);
    fire(0);
    fire(1);
    tick(4);
    take <= 1'b1;
    wait_ack(8'h03, 4'h0);
    tick(1);
    pin_n <= 6'h3f;
    tick(4);
    #1;
    chk("request", 8'(req), 8'h00);
    fire(2);
    wait_ack(8'h13, 4'h2);
    tick(1);
    pin_n <= 6'h3f;
    ret();
    tick(4);
    #1;
    chk("request", 8'(req), 8'h00);
    ret();
    wait_ack(8'h0b, 4'h1);
    ret();
    $display("test order and nesting done");
    tally_and_finish();
  end
endmodule
